// [flash_query_pkg.sv]
package flash_query_pkg;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int OFF_W  = 8;

  // Command bytes on the low data lane
  localparam logic [7:0] CMD_QUERY    = 8'h98;
  localparam logic [7:0] CMD_RESET    = 8'hf0;
  localparam logic [7:0] CMD_UNLOCK_A = 8'haa;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL  = 8'h90;

  // Command addresses, low address bits only
  localparam logic [7:0]  QUERY_CMD_ADDR = 8'h55;
  localparam logic [11:0] UNLOCK_ADDR_A  = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR_B  = 12'h2aa;

  // Boot sector flag codes
  localparam logic [7:0] BOOT_FLAG_BOTTOM = 8'h02;
  localparam logic [7:0] BOOT_FLAG_TOP    = 8'h03;

  // Unlock sequence progress
  localparam logic [1:0] UNLOCK_IDLE  = 2'h0;
  localparam logic [1:0] UNLOCK_FIRST = 2'h1;
  localparam logic [1:0] UNLOCK_BOTH  = 2'h2;

  typedef enum logic [1:0] {
    MODE_ARRAY   = 2'b00,
    MODE_AUTOSEL = 2'b01,
    MODE_QUERY   = 2'b10
  } mode_t;

  localparam mode_t RST_MODE = MODE_ARRAY;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } bus_resp_t;

  localparam bus_resp_t RST_RESP = '0;

  typedef struct packed {
    mode_t     mode;
    logic [1:0] unlock;
    bus_resp_t resp;
  } fq_state_t;

endpackage : flash_query_pkg

// [flash_query_table_responder.sv]
// Operation
// - Query command 98h at 55h enters query when array_ready is high or in identification mode
// - Reset command leaves query for array reads
// - Query command also accepted in identification mode
// - 10h-12h return Q, R, Y
// - 13h-14h command set, 15h-16h table pointer
// - 17h-1Ah return zero
// - Supply range words, no programming supply
// - Typical write and erase timeouts
// - Maximum timeout multipliers
// - 27h returns device size exponent
// - Interface description, no multi-byte write
// - Three erase regions, fourth region zero
// - Regions one and three descriptor words
// - Region two descriptor words
// - P, R, I signature and version digits
// - Unlock and erase suspend capability words
// - Protection group, unprotect, scheme words
// - Simultaneous sectors, burst, no page mode
// - Acceleration supply range words
// - Boot flag and no program suspend
// - Bank count and per-bank sector counts
// - Unlock sequence enters identification mode
// - Identification mode only in asynchronous reads
`timescale 1ns/1ps

module flash_query_table_responder #(
  parameter logic [15:0] CMDSET_ID = 16'h00a7, // Arbitrary value
  parameter logic [7:0]  VER_MAJOR = 8'h3a,    // Arbitrary value
  parameter logic [7:0]  VER_MINOR = 8'h3b,    // Arbitrary value
  parameter bit          TOP_BOOT  = 1'b0
) (
  input  wire logic                        mclk,        // 100 MHz clock
  input  wire logic                        nrst,        // Sync reset, low
  input  wire flash_query_pkg::bus_req_t   req,         // Host bus cycle
  input  wire logic                        array_ready, // Array reads allowed
  input  wire logic                        burst_mode,  // Synchronous reads on
  input  wire logic [15:0]                 array_rdata, // Array word
  input  wire logic [15:0]                 id_rdata,    // Identification word
  output flash_query_pkg::bus_resp_t       resp,        // Read answer
  output logic                             query_mode,  // Query table active
  output logic                             id_mode      // Identification active
);
  import flash_query_pkg::*;

  fq_state_t  st;
  fq_state_t  next_st;
  logic [7:0] cmd;
  logic [7:0] roff;
  logic       wr_reset;
  logic       wr_query;
  logic       wr_unlock_a;
  logic       wr_unlock_b;
  logic       wr_autosel;

  function automatic logic [7:0] query_word(input logic [7:0] off);
    logic [7:0] w;
    w = 8'h00;
    unique case (off)
      8'h10: w = 8'h51;
      8'h11: w = 8'h52;
      8'h12: w = 8'h59;
      8'h13: w = CMDSET_ID[7:0];
      8'h14: w = CMDSET_ID[15:8];
      8'h15: w = 8'h40;
      8'h16: w = 8'h00;
      8'h17, 8'h18, 8'h19, 8'h1a: w = 8'h00;
      8'h1b: w = 8'h17;
      8'h1c: w = 8'h19;
      8'h1d, 8'h1e: w = 8'h00;
      8'h1f: w = 8'h04;
      8'h20: w = 8'h00;
      8'h21: w = 8'h09;
      8'h22: w = 8'h00;
      8'h23: w = 8'h04;
      8'h24: w = 8'h00;
      8'h25: w = 8'h04;
      8'h26: w = 8'h00;
      8'h27: w = 8'h16;
      8'h28: w = 8'h01;
      8'h29: w = 8'h00;
      8'h2a, 8'h2b: w = 8'h00;
      8'h2c: w = 8'h03;
      8'h2d, 8'h35: w = 8'h03;
      8'h2e, 8'h36: w = 8'h00;
      8'h2f, 8'h37: w = 8'h40;
      8'h30, 8'h38: w = 8'h00;
      8'h31: w = 8'h3d;
      8'h32, 8'h33: w = 8'h00;
      8'h34: w = 8'h01;
      8'h39, 8'h3a, 8'h3b, 8'h3c: w = 8'h00;
      8'h40: w = 8'h50;
      8'h41: w = 8'h52;
      8'h42: w = 8'h49;
      8'h43: w = VER_MAJOR;
      8'h44: w = VER_MINOR;
      8'h45: w = 8'h04;
      8'h46: w = 8'h02;
      8'h47: w = 8'h01;
      8'h48: w = 8'h00;
      8'h49: w = 8'h05;
      8'h4a: w = 8'h33;
      8'h4b: w = 8'h01;
      8'h4c: w = 8'h00;
      8'h4d: w = 8'hb5;
      8'h4e: w = 8'hc5;
      8'h4f: w = TOP_BOOT ? BOOT_FLAG_TOP : BOOT_FLAG_BOTTOM;
      8'h50: w = 8'h00;
      8'h57: w = 8'h04;
      8'h58: w = 8'h13;
      8'h59: w = 8'h10;
      8'h5a: w = 8'h10;
      8'h5b: w = 8'h13;
      default: w = 8'h00;
    endcase
    return w;
  endfunction : query_word

  // Command decode on the low data byte
  assign cmd         = req.wdata[7:0];
  assign roff        = req.addr[OFF_W-1:0];
  assign wr_reset    = req.wr && (cmd == CMD_RESET);
  assign wr_query    = req.wr && (cmd == CMD_QUERY) && (req.addr[7:0] == QUERY_CMD_ADDR);
  assign wr_unlock_a = req.wr && (cmd == CMD_UNLOCK_A) && (req.addr[11:0] == UNLOCK_ADDR_A);
  assign wr_unlock_b = req.wr && (cmd == CMD_UNLOCK_B) && (req.addr[11:0] == UNLOCK_ADDR_B);
  assign wr_autosel  = req.wr && (cmd == CMD_AUTOSEL) && (req.addr[11:0] == UNLOCK_ADDR_A);

  always_comb begin
    next_st            = st;
    next_st.resp.valid = 1'b0;
    // Reads are served in the mode held before any write of the same cycle
    if (req.rd) begin
      next_st.resp.valid = 1'b1;
      unique case (st.mode)
        MODE_ARRAY:   next_st.resp.data = array_rdata;
        MODE_AUTOSEL: next_st.resp.data = id_rdata;
        MODE_QUERY:   next_st.resp.data = {8'h00, query_word(roff)};
        default:      next_st.resp.data = 16'h0000;
      endcase
    end
    if (wr_reset) begin
      next_st.mode   = MODE_ARRAY;
      next_st.unlock = UNLOCK_IDLE;
    end else if (req.wr) begin
      unique case (st.mode)
        MODE_ARRAY: begin
          if (wr_query && array_ready) begin
            next_st.mode   = MODE_QUERY;
            next_st.unlock = UNLOCK_IDLE;
          end else begin
            unique case (st.unlock)
              UNLOCK_IDLE: begin
                next_st.unlock = wr_unlock_a ? UNLOCK_FIRST : UNLOCK_IDLE;
              end
              UNLOCK_FIRST: begin
                next_st.unlock = wr_unlock_b ? UNLOCK_BOTH : UNLOCK_IDLE;
              end
              UNLOCK_BOTH: begin
                next_st.unlock = UNLOCK_IDLE;
                if (wr_autosel && !burst_mode) begin
                  next_st.mode = MODE_AUTOSEL;
                end
              end
              default: begin
                next_st.unlock = UNLOCK_IDLE;
              end
            endcase
          end
        end
        MODE_AUTOSEL: begin
          if (wr_query) begin
            next_st.mode = MODE_QUERY;
          end
        end
        MODE_QUERY: begin
          // Only the reset command leaves query mode
          next_st.mode = MODE_QUERY;
        end
        default: begin
          next_st.mode   = MODE_ARRAY;
          next_st.unlock = UNLOCK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st.mode   <= RST_MODE;
      st.unlock <= UNLOCK_IDLE;
      st.resp   <= RST_RESP;
    end else begin
      st <= next_st;
    end
  end

  assign resp       = st.resp;
  assign query_mode = (st.mode == MODE_QUERY);
  assign id_mode    = (st.mode == MODE_AUTOSEL);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  AST_QUERY_ENTRY: assert property (
    (st.mode == MODE_ARRAY) && array_ready && req.wr && !wr_reset && cmd == 8'h98
      && req.addr[7:0] == 8'h55 |=> query_mode)
    else $error("query command from array mode did not enter query mode");

  AST_QUERY_BUSY: assert property (
    (st.mode == MODE_ARRAY) && !array_ready && wr_query |=> !query_mode)
    else $error("query mode entered while array not ready");

  AST_QUERY_PERSIST: assert property (
    query_mode && !wr_reset |=> query_mode)
    else $error("query mode left without reset command");

  AST_RESET_EXIT: assert property (
    wr_reset |=> !query_mode && !id_mode)
    else $error("reset command did not return to array reads");

  AST_AUTOSEL_TO_QUERY: assert property (
    id_mode && wr_query |=> query_mode)
    else $error("query command ignored in identification mode");

  AST_QRY_STRING: assert property (
    query_mode && req.rd && !req.wr && roff == 8'h10 ##1 req.rd && roff == 8'h11
      |-> ##1 resp.data == 16'h0052 && $past(resp.data) == 16'h0051)
    else $error("query signature words wrong");

  AST_SIZE_WORD: assert property (
    query_mode && req.rd && roff == 8'h27 |=> resp.valid && resp.data == 16'h0016)
    else $error("device size word wrong");

  AST_REGIONS: assert property (
    query_mode && req.rd && roff == 8'h2c |=> resp.data == 16'h0003)
    else $error("erase region count wrong");

  AST_PRI_STRING: assert property (
    query_mode && req.rd && roff == 8'h40 |=> resp.data == 16'h0050)
    else $error("extended table signature wrong");

  AST_ACC_MIN: assert property (
    query_mode && req.rd && roff == 8'h4d |=> resp.data == 16'h00b5)
    else $error("acceleration supply minimum wrong");

  AST_BANK_A: assert property (
    query_mode && req.rd && roff == 8'h58 |=> resp.data == 16'h0013)
    else $error("bank A sector count wrong");

  AST_CMDSET_LOW: assert property (
    query_mode && req.rd && roff == 8'h13 |=> resp.data == {8'h00, CMDSET_ID[7:0]})
    else $error("command set identifier low word wrong");

  AST_EXT_PTR: assert property (
    query_mode && req.rd && roff == 8'h15 |=> resp.data == 16'h0040)
    else $error("extended table pointer wrong");

  AST_NO_ALT: assert property (
    query_mode && req.rd && roff >= 8'h17 && roff <= 8'h1a |=> resp.data == 16'h0000)
    else $error("alternate command set words not zero");

  AST_VCC_MIN: assert property (
    query_mode && req.rd && roff == 8'h1b |=> resp.data == 16'h0017)
    else $error("supply minimum word wrong");

  AST_VCC_MAX: assert property (
    query_mode && req.rd && roff == 8'h1c |=> resp.data == 16'h0019)
    else $error("supply maximum word wrong");

  AST_WRITE_TYP: assert property (
    query_mode && req.rd && roff == 8'h1f |=> resp.data == 16'h0004)
    else $error("typical word write timeout wrong");

  AST_ERASE_TYP: assert property (
    query_mode && req.rd && roff == 8'h21 |=> resp.data == 16'h0009)
    else $error("typical block erase timeout wrong");

  AST_IFACE: assert property (
    query_mode && req.rd && roff == 8'h28 |=> resp.data == 16'h0001)
    else $error("interface description word wrong");

  AST_REGION_ONE: assert property (
    query_mode && req.rd && roff == 8'h2d |=> resp.data == 16'h0003)
    else $error("region one first word wrong");

  AST_REGION_TWO: assert property (
    query_mode && req.rd && roff == 8'h31 |=> resp.data == 16'h003d)
    else $error("region two first word wrong");

  AST_REGION_FOUR: assert property (
    query_mode && req.rd && roff >= 8'h39 && roff <= 8'h3c |=> resp.data == 16'h0000)
    else $error("fourth region words not zero");

  AST_UNLOCK_CAP: assert property (
    query_mode && req.rd && roff == 8'h45 |=> resp.data == 16'h0004)
    else $error("unlock capability word wrong");

  AST_SUSPEND: assert property (
    query_mode && req.rd && roff == 8'h46 |=> resp.data == 16'h0002)
    else $error("erase suspend word wrong");

  AST_PROT_SCHEME: assert property (
    query_mode && req.rd && roff == 8'h49 |=> resp.data == 16'h0005)
    else $error("protection scheme word wrong");

  AST_SIMUL_SECT: assert property (
    query_mode && req.rd && roff == 8'h4a |=> resp.data == 16'h0033)
    else $error("simultaneous sector count wrong");

  AST_BOOT_FLAG: assert property (
    query_mode && req.rd && roff == 8'h4f |=> resp.data == (TOP_BOOT ? 16'h0003 : 16'h0002))
    else $error("boot flag word wrong");

  AST_BANK_COUNT: assert property (
    query_mode && req.rd && roff == 8'h57 |=> resp.data == 16'h0004)
    else $error("bank count word wrong");

  AST_ID_READ: assert property (
    id_mode && req.rd |=> resp.data == $past(id_rdata))
    else $error("identification read did not return identification word");

  AST_ARRAY_READ: assert property (
    !query_mode && !id_mode && req.rd |=> resp.data == $past(array_rdata))
    else $error("array read did not return array word");

  AST_VALID_ONE: assert property (
    !req.rd |=> !resp.valid)
    else $error("read answer without read request");

  AST_ASYNC_ONLY: assert property (
    !id_mode ##1 id_mode |-> !$past(burst_mode))
    else $error("identification mode entered during burst reads");

  AST_UPPER_ZERO: assert property (
    query_mode && req.rd |=> resp.valid && resp.data[15:8] == 8'h00)
    else $error("query word upper byte not zero");

  AST_UNLISTED: assert property (
    query_mode && req.rd && roff == 8'h55 |=> resp.data == 16'h0000)
    else $error("unlisted query offset not zero");

  AST_HIGH_ADDR: assert property (
    query_mode && req.rd && roff == 8'h2f && req.addr[ADDR_W-1:OFF_W] != '0 |=> resp.data == 16'h0040)
    else $error("high address bits changed query decode");

  AST_READ_VALID: assert property (
    req.rd |=> resp.valid ##0 (!$past(req.rd, 1) || resp.valid))
    else $error("read not answered after one cycle");

  COV_QUERY_FROM_ARRAY: cover property (!query_mode && !id_mode ##1 query_mode);
  COV_QUERY_FROM_ID: cover property (id_mode ##1 query_mode);
  COV_QUERY_EXIT: cover property (query_mode ##1 wr_reset ##1 !query_mode);
  COV_QUERY_READS: cover property (query_mode && req.rd [*3]);
  COV_ID_ENTRY: cover property (!id_mode ##1 id_mode);

endmodule : flash_query_table_responder

// [flash_host_model.sv]
`timescale 1ns/1ps

module flash_host_model (
  input  wire logic                      mclk, // Bus clock
  input  wire flash_query_pkg::bus_resp_t resp, // Read answer
  output flash_query_pkg::bus_req_t       req   // Host bus cycle
);
  import flash_query_pkg::*;

  initial req = '0;

  // Idle bus shows the inverse of the last address and data
  task automatic release_bus;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
  endtask : release_bus

  // One write cycle, launched and released on falling edges
  task automatic bus_write(input logic [20:0] a, input logic [15:0] d);
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    release_bus();
  endtask : bus_write

  // Answer registered on the taking edge, sampled half a cycle later
  task automatic bus_read(input logic [20:0] a, output bus_resp_t r);
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
    @(negedge mclk);
    r = resp;
    release_bus();
  endtask : bus_read

  // Three reads on consecutive cycles, each answer taken before the next address
  task automatic bus_read3(input logic [20:0] a0, a1, a2, output bus_resp_t r0, r1, r2);
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a0, wdata: ~req.wdata};
    @(negedge mclk);
    r0 = resp;
    req = '{wr: 1'b0, rd: 1'b1, addr: a1, wdata: ~req.wdata};
    @(negedge mclk);
    r1 = resp;
    req = '{wr: 1'b0, rd: 1'b1, addr: a2, wdata: ~req.wdata};
    @(negedge mclk);
    r2 = resp;
    release_bus();
  endtask : bus_read3
endmodule : flash_host_model

// [flash_query_table_responder_tb.sv]
`timescale 1ns/1ps

module flash_query_table_responder_tb;
  import flash_query_pkg::*;
  localparam logic [15:0] CSET = 16'h5a3c; // Arbitrary value
  localparam logic [7:0]  VMAJ = 8'h4d;    // Arbitrary value
  localparam logic [7:0]  VMIN = 8'h4e;    // Arbitrary value
  logic        mclk = 1'b0, nrst = 1'b0, array_ready = 1'b0, burst_mode = 1'b0;
  logic [15:0] array_rdata = '0, id_rdata = '0, d;
  logic [31:0] seed = 32'h1be0b66c;
  bus_req_t    req;
  bus_resp_t   resp, r, r0, r1, r2;
  logic        query_mode, id_mode;
  int          n_errors = 0, total_checks = 0;

  always #5 mclk = ~mclk;

  flash_query_table_responder #(.CMDSET_ID(CSET), .VER_MAJOR(VMAJ), .VER_MINOR(VMIN), .TOP_BOOT(1'b1)) uut (
    .mclk(mclk), .nrst(nrst), .req(req), .array_ready(array_ready), .burst_mode(burst_mode),
    .array_rdata(array_rdata), .id_rdata(id_rdata), .resp(resp), .query_mode(query_mode), .id_mode(id_mode));

  flash_host_model host (.mclk(mclk), .resp(resp), .req(req));

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Random bank and sector bits above the table offset
  function logic [20:0] hi(logic [7:0] o);
    seed = lfsr(seed);
    return {seed[12:0], o};
  endfunction : hi

  function automatic logic [15:0] exp_word(logic [7:0] o);
    logic [7:0] b;
    case (o)
      8'h10: b = 8'h51;  8'h11: b = 8'h52;  8'h12: b = 8'h59;  8'h13: b = CSET[7:0];
      8'h14: b = CSET[15:8];  8'h15: b = 8'h40;  8'h1b: b = 8'h17;  8'h1c: b = 8'h19;
      8'h1f, 8'h23, 8'h25, 8'h45, 8'h57: b = 8'h04;  8'h21: b = 8'h09;  8'h27: b = 8'h16;
      8'h28, 8'h34, 8'h47, 8'h4b: b = 8'h01;  8'h2c, 8'h2d, 8'h35: b = 8'h03;
      8'h2f, 8'h37: b = 8'h40;  8'h31: b = 8'h3d;  8'h40: b = 8'h50;  8'h41: b = 8'h52;
      8'h42: b = 8'h49;  8'h43: b = VMAJ;  8'h44: b = VMIN;  8'h46: b = 8'h02;  8'h49: b = 8'h05;
      8'h4a: b = 8'h33;  8'h4d: b = 8'hb5;  8'h4e: b = 8'hc5;  8'h4f: b = 8'h03;
      8'h58, 8'h5b: b = 8'h13;  8'h59, 8'h5a: b = 8'h10;
      default: b = 8'h00;
    endcase
    return {8'h00, b};
  endfunction : exp_word

  task automatic check_word(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t word got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(logic got, logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t flag got %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic rd(logic [20:0] a, output logic [15:0] q);
    seed = lfsr(seed);
    array_rdata = seed[15:0];
    id_rdata = seed[31:16];
    host.bus_read(a, r);
    check_bit(r.valid, 1'b1);
    q = r.data;
  endtask : rd

  task automatic unlock;
    host.bus_write({9'h0, 12'h555}, 16'h00aa);
    host.bus_write({9'h0, 12'h2aa}, 16'h0055);
    host.bus_write({9'h0, 12'h555}, 16'h0090);
  endtask : unlock

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    #100us;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    check_bit(query_mode, 1'b0);
    host.bus_write(hi(8'h55), 16'h0098);
    check_bit(query_mode, 1'b0);
    array_ready = 1'b1;
    rd(hi(8'h10), d);
    check_word(d, array_rdata);
    host.bus_write(hi(8'h55), {seed[7:0], 8'h98});
    check_bit(query_mode, 1'b1);
    for (int i = 0; i < 256; i++) begin
      rd(hi(i[7:0]), d);
      check_word(d, exp_word(i[7:0]));
    end
    host.bus_read3(hi(8'h10), hi(8'h11), hi(8'h12), r0, r1, r2);
    check_word(r0.data, 16'h0051);
    check_word(r1.data, 16'h0052);
    check_word(r2.data, 16'h0059);
    check_bit(r2.valid, 1'b1);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    check_bit(query_mode, 1'b0);
    check_bit(resp.valid, 1'b0);
    nrst = 1'b1;
    host.bus_write(hi(8'h55), 16'h0098);
    check_bit(query_mode, 1'b1);
    host.bus_write(hi(8'h55), 16'h0090);
    check_bit(query_mode, 1'b1);
    host.bus_write(hi(8'h00), 16'h00f0);
    check_bit(query_mode, 1'b0);
    rd(hi(8'h11), d);
    check_word(d, array_rdata);
    for (int k = 0; k < 2; k++) begin
      burst_mode = (k == 0);
      array_ready = 1'b0;
      unlock();
      check_bit(id_mode, k == 1);
    end
    rd(hi(8'h01), d);
    check_word(d, id_rdata);
    host.bus_write(hi(8'h55), 16'h0098);
    check_bit(query_mode, 1'b1);
    check_bit(id_mode, 1'b0);
    rd(hi(8'h12), d);
    check_word(d, 16'h0059);
    host.bus_write(hi(8'h3c), 16'h00f0);
    check_bit(query_mode, 1'b0);
    check_bit(id_mode, 1'b0);
    report_and_stop();
  end
endmodule : flash_query_table_responder_tb
